/* File: design/gcs_gate.sv */
// Network gate: enable is taken only at a falling edge of the chosen clock.
// Assumes sel_clk is a level already in the aclk domain.
`timescale 1ns/1ns
`default_nettype none
module gcs_gate (
  input  wire logic aclk,
  input  wire logic aresetn,
  gcs_net_if.gate   nif
);
  logic prev_q;
  logic gate_q;
  logic net_q;
  logic fall;

  assign fall          = prev_q & ~nif.sel_clk;
  assign nif.net_out   = net_q;
  assign nif.gate_open = gate_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
      gate_q <= 1'b0;
      net_q  <= 1'b0;
    end else begin
      prev_q <= nif.sel_clk;
      if (fall) begin
        gate_q <= nif.gate_req;
      end
      // Gate moves only while the clock is low, so no pulse is cut short
      net_q  <= nif.sel_clk & gate_q;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  gate_on_fall_a: assert property ($changed(gate_q) |-> $past(prev_q) && !$past(nif.sel_clk))
    else $error("gate changed away from a falling edge");
  net_needs_gate_a: assert property (net_q |-> $past(gate_q) && $past(nif.sel_clk))
    else $error("network high without open gate");
  no_runt_a: assert property ($fell(gate_q) |-> !net_q ##1 !net_q)
    else $error("truncated pulse at disable");
endmodule : gcs_gate
`default_nettype wire

/* File: design/gcs_net_if.sv */
// Carrier between the selection logic and the network gate.
// Assumes both ends run on the same aclk.
`timescale 1ns/1ns
`default_nettype none
interface gcs_net_if;
  logic sel_clk;
  logic gate_req;
  logic net_out;
  logic gate_open;

  modport src  (output sel_clk, output gate_req, input net_out, input gate_open);
  modport gate (input sel_clk, input gate_req, output net_out, output gate_open);
endinterface : gcs_net_if
`default_nettype wire

/* File: design/gcs_pkg.sv */
// Constants shared by the global clock select and gate cell.
// Assumes every user refers to them as gcs_pkg::name, with no import.
package gcs_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry and answers
  // ----------------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0]  CFG_OFS     = 4'h0;
  localparam logic [3:0]  CTRL_OFS    = 4'h4;
  localparam logic [3:0]  STAT_OFS    = 4'h8;

  // ----------------------------------------------------------------------
  // Static configuration word
  // ----------------------------------------------------------------------
  localparam int          CFG_W           = 9;
  localparam int          CFG_ROUTE_LSB   = 0;
  localparam int          CFG_CORNER_BIT  = 2;
  localparam int          CFG_LOOPA_LSB   = 3;
  localparam int          CFG_LOOPB_LSB   = 5;
  localparam int          CFG_REFSTAT_BIT = 7;
  localparam int          CFG_REFMAN_BIT  = 8;
  localparam logic [8:0]  CFG_RESET       = 9'h020;

  // ----------------------------------------------------------------------
  // Control and status fields
  // ----------------------------------------------------------------------
  localparam int          CTRL_MODE_BIT   = 0;
  localparam logic        MODE_RESET      = 1'b0;
  localparam int          STAT_MODE_BIT   = 0;
  localparam int          STAT_GATE_BIT   = 1;
  localparam int          STAT_NET_BIT    = 2;
  localparam int          STAT_REFOK_BIT  = 3;
  localparam int          STAT_SEL_LSB    = 4;
  localparam int          STAT_ROUTE_LSB  = 6;

  // ----------------------------------------------------------------------
  // Static route and run-time source codes
  // ----------------------------------------------------------------------
  localparam logic [1:0]  ROUTE_RUNTIME   = 2'h0;
  localparam logic [1:0]  ROUTE_DUAL      = 2'h1;
  localparam logic [1:0]  ROUTE_LOGIC     = 2'h2;
  localparam logic [1:0]  SEL_PIN0        = 2'h0;
  localparam logic [1:0]  SEL_PIN1        = 2'h1;
  localparam logic [1:0]  SEL_LOOPA       = 2'h2;

  // ----------------------------------------------------------------------
  // Synchroniser bank layout
  // ----------------------------------------------------------------------
  localparam int          SYNC_W          = 9;
  localparam int          SY_PIN_LSB      = 0;
  localparam int          SY_LOOP_LSB     = 2;
  localparam int          SY_DUAL_BIT     = 6;
  localparam int          SY_CORNER_LSB   = 7;

endpackage : gcs_pkg

/* File: design/gcs_sync.sv */
// Two-flop synchroniser bank for the candidate pins.
// Assumes each bit is an independent level from outside the aclk domain.
`timescale 1ns/1ns
`default_nettype none
module gcs_sync #(
  parameter int W = gcs_pkg::SYNC_W
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : gcs_sync
`default_nettype wire

/* File: design/gcs_top.sv */
// Global clock select and gate cell, top level with AXI4-Lite registers.
// Assumes candidate pins are asynchronous to aclk and sampled here; user
// logic driving source_select, gate_enable and pll_input_switch is on aclk.
`timescale 1ns/1ns
`default_nettype none
module gcs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Candidates
  input  wire logic [1:0]  clock_pin,
  input  wire logic [3:0]  loop_offer,
  input  wire logic        dual_purpose_clock_pin,
  input  wire logic [1:0]  corner_dual_purpose_pin,
  input  wire logic        logic_source,
  // User logic controls
  input  wire logic [1:0]  source_select,
  input  wire logic        gate_enable,
  input  wire logic        pll_input_switch,
  // Outputs
  output logic             global_clock_network,
  output logic             loop_reference,
  output logic             network_loop_ref
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic pick4(input logic [3:0] v, input logic [1:0] idx);
    pick4 = v[idx];
  endfunction : pick4

  function automatic logic [31:0] widen(input logic [7:0] v);
    widen = {24'h000000, v};
  endfunction : widen

  // ----------------------------------------------------------------------
  // Candidate synchronisers
  // ----------------------------------------------------------------------
  logic [gcs_pkg::SYNC_W-1:0] raw_in;
  logic [gcs_pkg::SYNC_W-1:0] syn;
  logic [1:0]                 pin_s;
  logic [3:0]                 offer_s;
  logic                       dual_s;
  logic [1:0]                 corner_s;

  assign raw_in = {corner_dual_purpose_pin, dual_purpose_clock_pin, loop_offer, clock_pin};

  gcs_sync #(.W(gcs_pkg::SYNC_W)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (raw_in),
    .sync_out (syn)
  );

  assign pin_s    = syn[gcs_pkg::SY_PIN_LSB +: 2];
  assign offer_s  = syn[gcs_pkg::SY_LOOP_LSB +: 4];
  assign dual_s   = syn[gcs_pkg::SY_DUAL_BIT];
  assign corner_s = syn[gcs_pkg::SY_CORNER_LSB +: 2];

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [gcs_pkg::CFG_W-1:0] cfg_q;
  logic                      mode_q;
  logic [1:0]                route;
  logic                      corner_pick;
  logic [1:0]                loopa_pick;
  logic [1:0]                loopb_pick;
  logic                      ref_static;
  logic                      ref_manual;

  assign route       = cfg_q[gcs_pkg::CFG_ROUTE_LSB +: 2];
  assign corner_pick = cfg_q[gcs_pkg::CFG_CORNER_BIT];
  assign loopa_pick  = cfg_q[gcs_pkg::CFG_LOOPA_LSB +: 2];
  assign loopb_pick  = cfg_q[gcs_pkg::CFG_LOOPB_LSB +: 2];
  assign ref_static  = cfg_q[gcs_pkg::CFG_REFSTAT_BIT];
  assign ref_manual  = cfg_q[gcs_pkg::CFG_REFMAN_BIT];

  // ----------------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------------
  logic       loop_a;
  logic       loop_b;
  logic       corner_src;
  logic       dual_src;
  logic       runtime_clk;
  logic       chosen_clk;
  logic [1:0] sel_eff;

  // Five counter outputs per loop exist; four shared offers come in here, and each loop may pick any of them
  assign loop_a     = pick4(offer_s, loopa_pick);
  assign loop_b     = pick4(offer_s, loopb_pick);
  assign corner_src = corner_pick ? corner_s[1] : corner_s[0];
  assign dual_src   = dual_s | corner_src;
  // Ignored until user mode; SEL_PIN0 is used during configuration
  assign sel_eff    = mode_q ? source_select : gcs_pkg::SEL_PIN0;

  // No handover logic: a select change can cut a pulse, so gate around it
  assign runtime_clk = (sel_eff == gcs_pkg::SEL_PIN0)  ? pin_s[0] :
                       (sel_eff == gcs_pkg::SEL_PIN1)  ? pin_s[1] :
                       (sel_eff == gcs_pkg::SEL_LOOPA) ? loop_a   :
                                                         loop_b;

  assign chosen_clk  = (route == gcs_pkg::ROUTE_RUNTIME) ? runtime_clk :
                       (route == gcs_pkg::ROUTE_DUAL)    ? dual_src    :
                       (route == gcs_pkg::ROUTE_LOGIC)   ? logic_source :
                                                           1'b0;

  // ----------------------------------------------------------------------
  // Network gate
  // ----------------------------------------------------------------------
  gcs_net_if nif ();

  assign nif.sel_clk  = chosen_clk;
  assign nif.gate_req = mode_q & gate_enable;

  gcs_gate u_gate (
    .aclk    (aclk),
    .aresetn (aresetn),
    .nif     (nif)
  );

  assign global_clock_network = nif.net_out;

  // ----------------------------------------------------------------------
  // Loop reference paths
  // ----------------------------------------------------------------------
  logic ref_sw;
  logic ref_ok;
  logic loop_ref_q;
  logic net_ref_q;

  assign ref_sw = ref_manual ? pll_input_switch : ref_static;
  assign ref_ok = (route == gcs_pkg::ROUTE_RUNTIME);

  // Reference mux ignores the gate, so a loop keeps its lock while dark
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_ref_q <= 1'b0;
      net_ref_q  <= 1'b0;
    end else begin
      loop_ref_q <= ref_sw ? pin_s[1] : pin_s[0];
      net_ref_q  <= ref_ok & nif.net_out;
    end
  end

  assign loop_reference   = loop_ref_q;
  assign network_loop_ref = net_ref_q;

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  logic       aw_full_q;
  logic [3:0] aw_addr_q;
  logic       w_full_q;
  logic [8:0] w_data_q;
  logic       w_lane0_q;
  logic       w_lane1_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;
  logic       do_write;
  logic       hit_cfg;
  logic       hit_ctrl;
  logic       cfg_open;
  logic [1:0] wr_resp;

  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready  = ~w_full_q & ~bvalid_q;
  assign do_write      = aw_full_q & w_full_q & ~bvalid_q;
  assign hit_cfg       = (aw_addr_q == gcs_pkg::CFG_OFS);
  assign hit_ctrl      = (aw_addr_q == gcs_pkg::CTRL_OFS);
  assign cfg_open      = ~mode_q;
  assign wr_resp       = (hit_cfg & cfg_open) | hit_ctrl ? gcs_pkg::RESP_OKAY
                                                         : gcs_pkg::RESP_SLVERR;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 4'h0;
    end else if (s_axi_awvalid & s_axi_awready) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= {s_axi_awaddr[3:2], 2'b00};
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q  <= 1'b0;
      w_data_q  <= 9'h000;
      w_lane0_q <= 1'b0;
      w_lane1_q <= 1'b0;
    end else if (s_axi_wvalid & s_axi_wready) begin
      w_full_q  <= 1'b1;
      w_data_q  <= s_axi_wdata[8:0];
      w_lane0_q <= s_axi_wstrb[0];
      w_lane1_q <= s_axi_wstrb[1];
    end else if (do_write) begin
      w_full_q  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= gcs_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_resp;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Static bits load only before user mode; the mode bit is set-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q  <= gcs_pkg::CFG_RESET;
      mode_q <= gcs_pkg::MODE_RESET;
    end else if (do_write) begin
      if (hit_cfg & cfg_open & w_lane0_q) begin
        cfg_q[7:0] <= w_data_q[7:0];
      end
      if (hit_cfg & cfg_open & w_lane1_q) begin
        cfg_q[8] <= w_data_q[8];
      end
      if (hit_ctrl & w_lane0_q & w_data_q[gcs_pkg::CTRL_MODE_BIT]) begin
        mode_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [3:0]  rd_addr;
  logic [7:0]  status;
  logic        rd_known;
  logic [31:0] rd_word;

  assign rd_addr  = {s_axi_araddr[3:2], 2'b00};
  assign status   = {route, sel_eff, ref_ok, nif.net_out, nif.gate_open, mode_q};
  assign rd_known = (rd_addr == gcs_pkg::CFG_OFS) | (rd_addr == gcs_pkg::CTRL_OFS) |
                    (rd_addr == gcs_pkg::STAT_OFS);
  assign rd_word  = (rd_addr == gcs_pkg::CFG_OFS)  ? {23'h000000, cfg_q} :
                    (rd_addr == gcs_pkg::CTRL_OFS) ? {31'h00000000, mode_q} :
                    (rd_addr == gcs_pkg::STAT_OFS) ? widen(status) :
                                                     32'h00000000;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= gcs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_known ? gcs_pkg::RESP_OKAY : gcs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  cfg_frozen_a: assert property (mode_q |=> $stable(cfg_q))
    else $error("static bits changed in user mode");
  mode_sticky_a: assert property (mode_q |=> mode_q)
    else $error("user mode dropped without reset");
  dark_before_mode_a: assert property (!mode_q |-> !global_clock_network)
    else $error("network active before user mode");
  ref_barred_a: assert property (route != gcs_pkg::ROUTE_RUNTIME |=> !network_loop_ref)
    else $error("barred route reached loop reference");
  ref_follow_a: assert property (ref_ok && global_clock_network |=> network_loop_ref)
    else $error("allowed network missing from loop reference");
  logic_route_a: assert property (route == gcs_pkg::ROUTE_LOGIC |-> nif.sel_clk == logic_source)
    else $error("logic route not taken");
  write_answer_a: assert property (do_write |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule : gcs_top
`default_nettype wire

/* File: dv/gcs_top_tb.sv */
// Self-checking bench for the global clock select and gate cell.
// Assumes gcs_pkg, the design and gcs_user_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("[ERR] %s expected %h seen %h", nm, (e), (g)); \
    end \
  end
module gcs_top_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [3:0]  cyc = 4'h0;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, sel;
  logic        awready, wready, bvalid, arready, rvalid, net, lref, nref, en, sw;
  int          mismatches, checks_done, tick;
  // Candidates are slow square waves of periods 2 to 16 cycles
  wire logic [1:0] pins = {cyc[2], cyc[1]};
  wire logic [3:0] ofr  = {~cyc[3], ~cyc[1], ~cyc[2], cyc[3]};

  gcs_top dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .clock_pin(pins), .loop_offer(ofr), .dual_purpose_clock_pin(cyc[1] ^ cyc[2]),
    .corner_dual_purpose_pin({cyc[3], cyc[0]}), .logic_source(cyc[3]),
    .source_select(sel), .gate_enable(en), .pll_input_switch(sw),
    .global_clock_network(net), .loop_reference(lref), .network_loop_ref(nref));
  gcs_user_model user_u (.aclk(aclk), .source_select(sel), .gate_enable(en),
    .pll_input_switch(sw));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 4'h1;
    tick <= tick + 1;
    if (tick == 3000) begin
      mismatches++;
      end_of_test();
    end
  end

  // --------------------------------------------------------------------
  // Bus and observation tasks
  // --------------------------------------------------------------------
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    `CHK("rdata", ed, rdata)
    `CHK("rresp", er, rresp)
  endtask : axi_read

  function automatic logic exp_src(input logic [8:0] cf, input logic [1:0] s,
                                   input logic [3:0] c);
    logic [3:0] o;
    o = {~c[3], ~c[1], ~c[2], c[3]};
    case (cf[1:0])
      2'h0:    exp_src = s[1] ? o[s[0] ? cf[6:5] : cf[4:3]] : (s[0] ? c[2] : c[1]);
      2'h1:    exp_src = (c[1] ^ c[2]) | (cf[2] ? c[3] : c[0]);
      2'h2:    exp_src = c[3];
      default: exp_src = 1'b0;
    endcase
  endfunction : exp_src

  // Synchronised candidates land three edges late, the logic source one
  task automatic watch(input logic [8:0] cf, input logic [1:0] s, input logic on, input int n);
    logic [3:0] c;
    logic [3:0] c3;
    repeat (n) begin
      @(negedge aclk);
      c  = cyc - ((cf[1:0] == 2'h2) ? 4'h1 : 4'h3);
      c3 = cyc - 4'h3;
      `CHK("network", on & exp_src(cf, s, c), net)
      `CHK("net ref", on & (cf[1:0] == 2'h0) & exp_src(cf, s, c - 4'h1), nref)
      `CHK("loop input", (cf[8] ? sw : cf[7]) ? c3[2] : c3[1], lref)
    end
  endtask : watch

  task automatic phase(input logic [31:0] cfg);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_write(gcs_pkg::CFG_OFS, cfg, gcs_pkg::RESP_OKAY);
    axi_write(gcs_pkg::CTRL_OFS, 32'h1, gcs_pkg::RESP_OKAY);
  endtask : phase

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // --------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = '0;
    {aresetn, mismatches, checks_done} = '0;
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(gcs_pkg::CFG_OFS, 32'h020, gcs_pkg::RESP_OKAY);
    axi_read(gcs_pkg::STAT_OFS, 32'h008, gcs_pkg::RESP_OKAY);
    axi_read(4'hC, 32'h0, gcs_pkg::RESP_SLVERR);
    wstrb <= 4'h2;
    axi_write(gcs_pkg::CFG_OFS, 32'h1FF, gcs_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    axi_read(gcs_pkg::CFG_OFS, 32'h120, gcs_pkg::RESP_OKAY);
    user_u.set_ref(1'b1);
    user_u.switch_to(2'h0);
    repeat (24) @(posedge aclk);
    watch(9'h120, 2'h0, 1'b0, 16);
    axi_write(gcs_pkg::CFG_OFS, 32'h170, gcs_pkg::RESP_OKAY);
    axi_write(gcs_pkg::CTRL_OFS, 32'h1, gcs_pkg::RESP_OKAY);
    axi_write(gcs_pkg::CFG_OFS, 32'h0, gcs_pkg::RESP_SLVERR);
    axi_write(gcs_pkg::STAT_OFS, 32'h1, gcs_pkg::RESP_SLVERR);
    axi_read(gcs_pkg::CFG_OFS, 32'h170, gcs_pkg::RESP_OKAY);
    for (int s = 0; s < 4; s++) begin
      user_u.switch_to(s[1:0]);
      repeat (24) @(posedge aclk);
      watch(9'h170, s[1:0], 1'b1, 32);
    end
    user_u.hold_off();
    user_u.set_ref(1'b0);
    repeat (24) @(posedge aclk);
    watch(9'h170, 2'h3, 1'b0, 16);
    phase(32'h175);
    user_u.switch_to(2'h2);
    repeat (24) @(posedge aclk);
    watch(9'h175, 2'h2, 1'b1, 32);
    phase(32'h172);
    user_u.switch_to(2'h1);
    repeat (24) @(posedge aclk);
    watch(9'h172, 2'h1, 1'b1, 32);
    end_of_test();
  end
endmodule : gcs_top_tb
`default_nettype wire

/* File: dv/gcs_user_model.sv */
// User logic that steers the cell: source select, gate enable, loop input switch.
// Assumes the bench calls its tasks one at a time; everything moves on aclk.
`timescale 1ns/1ns
`default_nettype none
module gcs_user_model (
  input  wire logic      aclk,
  output var  logic [1:0] source_select,
  output var  logic       gate_enable,
  output var  logic       pll_input_switch
);
  initial begin
    source_select    = 2'h0;
    gate_enable      = 1'b0;
    pll_input_switch = 1'b0;
  end

  // --------------------------------------------------------------------
  // Safe source change
  // --------------------------------------------------------------------
  // The select itself is not glitch free, so the gate is shut around it
  task automatic switch_to(input logic [1:0] s);
    @(posedge aclk);
    gate_enable <= 1'b0;
    repeat (20) @(posedge aclk);
    source_select <= s;
    repeat (8) @(posedge aclk);
    gate_enable <= 1'b1;
  endtask : switch_to

  task automatic hold_off();
    @(posedge aclk);
    gate_enable <= 1'b0;
  endtask : hold_off

  task automatic set_ref(input logic v);
    @(posedge aclk);
    pll_input_switch <= v;
  endtask : set_ref
endmodule : gcs_user_model
`default_nettype wire
